// File: verilog/hcob_bank.sv
// Hub option byte bank: storage, readback and applied configuration
`timescale 1ns/1ns
module hcob_bank
  import hcob_pkg::*;
#(
  parameter bit DEFAULT_SELF = 1'b1,
  parameter int DLY0_CYC = OC_DLY0_CYC,
  parameter int DLY1_CYC = OC_DLY1_CYC,
  parameter int DLY2_CYC = OC_DLY2_CYC,
  parameter int DLY3_CYC = OC_DLY3_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_load_done,
  input wire logic local_power_sense_pin,
  input wire logic overload_n_pin,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic hub_attach_enable,
  output logic self_powered,
  output logic full_speed_only,
  output logic frame_end_marker_off,
  output logic overload_sense_off,
  output logic overload_fault,
  output logic compound_device,
  output logic [2:1] fixed_port_bits,
  output logic [2:1] port_enabled,
  output logic [7:0] max_draw_self_value,
  output logic [8:0] max_draw_self_ma
);

  localparam logic [7:0] DEF_OPT_A = DEFAULT_SELF ? DEF_OPT_A_SELF : DEF_OPT_A_BUS;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] opt_a_q;
  logic [7:0] opt_b_q;
  logic [7:0] fixed_q;
  logic [7:0] off_self_q;
  logic [7:0] off_bus_q;
  logic [7:0] draw_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic attach_q;
  logic sense_s1_q;
  logic sense_s2_q;
  logic ovl_n_s1_q;
  logic ovl_n_s2_q;
  logic self_q;
  logic self_d;
  logic fs_q;
  logic eop_off_q;
  logic sense_off_q;
  logic compound_q;
  logic [2:1] fixed_bits_q;
  logic [2:1] port_en_q;
  logic [2:1] port_en_d;
  logic [7:0] draw_val_q;
  logic [8:0] draw_ma_q;
  logic [OC_CNT_W-1:0] limit_q;
  hcob_delay_type delay_sel;

  hcob_ovl_if #(.CNT_W(OC_CNT_W)) ovl ();

  // Reserved positions never reach storage
  function automatic logic [7:0] keep_bits(input logic [7:0] data, input logic [7:0] mask);
    keep_bits = data & mask;
  endfunction

  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      opt_a_q <= DEF_OPT_A;
      opt_b_q <= DEF_OPT_B;
    end
    else
    begin
      if (hit(cfg_wr, cfg_addr, ADDR_OPT_A))
        opt_a_q <= keep_bits(cfg_wdata, MASK_OPT_A);
      if (hit(cfg_wr, cfg_addr, ADDR_OPT_B))
        opt_b_q <= keep_bits(cfg_wdata, MASK_OPT_B);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fixed_q <= DEF_PORT;
      off_self_q <= DEF_PORT;
      off_bus_q <= DEF_PORT;
      draw_q <= DEF_DRAW_SELF;
    end
    else
    begin
      if (hit(cfg_wr, cfg_addr, ADDR_FIXED))
        fixed_q <= keep_bits(cfg_wdata, MASK_PORT);
      if (hit(cfg_wr, cfg_addr, ADDR_OFF_SELF))
        off_self_q <= keep_bits(cfg_wdata, MASK_PORT);
      if (hit(cfg_wr, cfg_addr, ADDR_OFF_BUS))
        off_bus_q <= keep_bits(cfg_wdata, MASK_PORT);
      if (hit(cfg_wr, cfg_addr, ADDR_DRAW_SELF))
        draw_q <= keep_bits(cfg_wdata, MASK_DRAW);
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= DATA_ZERO;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= cfg_rd;
      if (cfg_rd)
      begin
        unique case (cfg_addr)
          ADDR_OPT_A: rdata_q <= opt_a_q;
          ADDR_OPT_B: rdata_q <= opt_b_q;
          ADDR_FIXED: rdata_q <= fixed_q;
          ADDR_OFF_SELF: rdata_q <= off_self_q;
          ADDR_OFF_BUS: rdata_q <= off_bus_q;
          ADDR_DRAW_SELF: rdata_q <= draw_q;
          default: rdata_q <= DATA_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Attach gating
  // ----------------------------------------------------------------
  // Upstream attach waits for the loader; held until reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      attach_q <= 1'b0;
    else if (cfg_load_done)
      attach_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    // Reset to idle levels so no false power drop or overload follows reset
    if (rst)
    begin
      sense_s1_q <= DEFAULT_SELF;
      sense_s2_q <= DEFAULT_SELF;
      ovl_n_s1_q <= 1'b1;
      ovl_n_s2_q <= 1'b1;
    end
    else
    begin
      sense_s1_q <= local_power_sense_pin;
      sense_s2_q <= sense_s1_q;
      ovl_n_s1_q <= overload_n_pin;
      ovl_n_s2_q <= ovl_n_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Applied configuration
  // ----------------------------------------------------------------
  // Dynamic mode follows local power both ways
  always_comb
  begin
    if (opt_b_q[BIT_DYNAMIC])
      self_d = sense_s2_q;
    else
      self_d = opt_a_q[BIT_POWER_SOURCE];
  end

  always_comb
  begin
    if (self_d)
      port_en_d = ~off_self_q[BIT_PORT2:BIT_PORT1];
    else
      port_en_d = ~off_bus_q[BIT_PORT2:BIT_PORT1];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      self_q <= DEFAULT_SELF;
      port_en_q <= ~DEF_PORT[BIT_PORT2:BIT_PORT1];
    end
    else
    begin
      self_q <= self_d;
      port_en_q <= port_en_d;
    end
  end

  // Sensing off is honoured only while bus powered; otherwise ganged
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fs_q <= DEF_OPT_A[BIT_FULL_SPEED];
      eop_off_q <= DEF_OPT_A[BIT_FRAME_END_OFF];
      sense_off_q <= DEF_OPT_A[BIT_SENSE_NONE] && !DEFAULT_SELF;
      compound_q <= DEF_OPT_B[BIT_COMPOUND];
      fixed_bits_q <= DEF_PORT[BIT_PORT2:BIT_PORT1];
    end
    else
    begin
      fs_q <= opt_a_q[BIT_FULL_SPEED];
      eop_off_q <= opt_a_q[BIT_FRAME_END_OFF];
      sense_off_q <= opt_a_q[BIT_SENSE_NONE] && !self_d;
      compound_q <= opt_b_q[BIT_COMPOUND];
      fixed_bits_q <= fixed_q[BIT_PORT2:BIT_PORT1];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      draw_val_q <= DEF_DRAW_SELF;
      draw_ma_q <= 9'(DEF_DRAW_SELF) * 9'(DRAW_UNIT_MA);
    end
    else
    begin
      draw_val_q <= draw_q;
      draw_ma_q <= 9'(draw_q) * 9'(DRAW_UNIT_MA);
    end
  end

  // ----------------------------------------------------------------
  // Overload delay selection
  // ----------------------------------------------------------------
  assign delay_sel = hcob_delay_type'(opt_b_q[BIT_DELAY_HI:BIT_DELAY_LO]);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      limit_q <= OC_CNT_W'(DLY1_CYC);
    else
    begin
      unique case (delay_sel)
        HCOB_DELAY_0P1MS: limit_q <= OC_CNT_W'(DLY0_CYC);
        HCOB_DELAY_2MS: limit_q <= OC_CNT_W'(DLY1_CYC);
        HCOB_DELAY_4MS: limit_q <= OC_CNT_W'(DLY2_CYC);
        HCOB_DELAY_6MS: limit_q <= OC_CNT_W'(DLY3_CYC);
      endcase
    end
  end

  assign ovl.enable = !sense_off_q;
  assign ovl.fault_raw = !ovl_n_s2_q;
  assign ovl.limit = limit_q;

  hcob_ovl_timer #(.CNT_W(OC_CNT_W)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .ovl(ovl.timer)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign hub_attach_enable = attach_q;
  assign self_powered = self_q;
  assign full_speed_only = fs_q;
  assign frame_end_marker_off = eop_off_q;
  assign overload_sense_off = sense_off_q;
  assign overload_fault = ovl.fault;
  assign compound_device = compound_q;
  assign fixed_port_bits = fixed_bits_q;
  assign port_enabled = port_en_q;
  assign max_draw_self_value = draw_val_q;
  assign max_draw_self_ma = draw_ma_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write_a;
    cfg_wr && cfg_addr == ADDR_OPT_A;
  endsequence

  sequence s_write_b;
    cfg_wr && cfg_addr == ADDR_OPT_B;
  endsequence

  property p_power_static;
    @(posedge mclk) disable iff (rst)
    !opt_b_q[BIT_DYNAMIC] |=> self_powered == $past(opt_a_q[BIT_POWER_SOURCE]);
  endproperty
  a_power_static: assert property (p_power_static) else $error("static power mode wrong");

  property p_power_dynamic;
    @(posedge mclk) disable iff (rst)
    opt_b_q[BIT_DYNAMIC] |=> self_powered == $past(sense_s2_q);
  endproperty
  a_power_dynamic: assert property (p_power_dynamic) else $error("dynamic power mode wrong");

  property p_dynamic_follow;
    @(posedge mclk) disable iff (rst)
    s_write_b ##0 cfg_wdata[BIT_DYNAMIC] ##1 !cfg_wr[*2] |-> ##1 self_powered == $past(sense_s2_q);
  endproperty
  a_dynamic_follow: assert property (p_dynamic_follow) else $error("power mode ignores local power");

  property p_full_speed;
    @(posedge mclk) disable iff (rst)
    s_write_a |-> ##2 full_speed_only == $past(cfg_wdata[BIT_FULL_SPEED], 2);
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("full speed option not applied");

  property p_frame_end;
    @(posedge mclk) disable iff (rst)
    s_write_a |-> ##2 frame_end_marker_off == $past(cfg_wdata[BIT_FRAME_END_OFF], 2);
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end option not applied");

  property p_sense_self;
    @(posedge mclk) disable iff (rst)
    self_powered |-> !overload_sense_off;
  endproperty
  a_sense_self: assert property (p_sense_self) else $error("sensing off while self powered");

  property p_compound;
    @(posedge mclk) disable iff (rst)
    s_write_b |-> ##2 compound_device == $past(cfg_wdata[BIT_COMPOUND], 2);
  endproperty
  a_compound: assert property (p_compound) else $error("compound flag not applied");

  property p_fixed_read;
    @(posedge mclk) disable iff (rst)
    cfg_rd && cfg_addr == ADDR_FIXED |=> cfg_rvalid && cfg_rdata[0] == 1'b0 && cfg_rdata[7:3] == 5'h00;
  endproperty
  a_fixed_read: assert property (p_fixed_read) else $error("fixed mask reserved bits set");

  property p_port_self;
    @(posedge mclk) disable iff (rst)
    self_d |=> port_enabled == ~$past(off_self_q[BIT_PORT2:BIT_PORT1]);
  endproperty
  a_port_self: assert property (p_port_self) else $error("self powered port mask wrong");

  property p_port_bus;
    @(posedge mclk) disable iff (rst)
    !self_d |=> port_enabled == ~$past(off_bus_q[BIT_PORT2:BIT_PORT1]);
  endproperty
  a_port_bus: assert property (p_port_bus) else $error("bus powered port mask wrong");

  property p_draw_units;
    @(posedge mclk) disable iff (rst)
    max_draw_self_ma == {max_draw_self_value, 1'b0};
  endproperty
  a_draw_units: assert property (p_draw_units) else $error("draw not in 2 mA units");

  property p_attach;
    @(posedge mclk) disable iff (rst)
    $rose(hub_attach_enable) |-> $past(cfg_load_done);
  endproperty
  a_attach: assert property (p_attach) else $error("attach before load done");

  property p_reserved;
    @(posedge mclk) disable iff (rst)
    (opt_a_q & ~MASK_OPT_A) == DATA_ZERO && (opt_b_q & ~MASK_OPT_B) == DATA_ZERO;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved option bit stored");

  property p_delay_select;
    @(posedge mclk) disable iff (rst)
    opt_b_q[BIT_DELAY_HI:BIT_DELAY_LO] == 2'b00 |=> limit_q == OC_CNT_W'(DLY0_CYC);
  endproperty
  a_delay_select: assert property (p_delay_select) else $error("shortest overload delay wrong");

endmodule

// File: verilog/hcob_pkg.sv
// Constants and types for the hub option byte bank
package hcob_pkg;

  // ----------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPT_A = 8'h06;
  localparam logic [7:0] ADDR_OPT_B = 8'h07;
  localparam logic [7:0] ADDR_FIXED = 8'h08;
  localparam logic [7:0] ADDR_OFF_SELF = 8'h09;
  localparam logic [7:0] ADDR_OFF_BUS = 8'h0A;
  localparam logic [7:0] ADDR_DRAW_SELF = 8'h0B;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWER_SOURCE = 7;
  localparam int BIT_FULL_SPEED = 5;
  localparam int BIT_FRAME_END_OFF = 3;
  localparam int BIT_SENSE_NONE = 2;
  localparam int BIT_DYNAMIC = 7;
  localparam int BIT_DELAY_HI = 5;
  localparam int BIT_DELAY_LO = 4;
  localparam int BIT_COMPOUND = 3;
  localparam int BIT_PORT1 = 1;
  localparam int BIT_PORT2 = 2;

  // ----------------------------------------------------------------
  // Writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_OPT_A = 8'hAE;
  localparam logic [7:0] MASK_OPT_B = 8'hB8;
  localparam logic [7:0] MASK_PORT = 8'h06;
  localparam logic [7:0] MASK_DRAW = 8'hFF;
  localparam logic [7:0] DEF_OPT_A_SELF = 8'h88;
  localparam logic [7:0] DEF_OPT_A_BUS = 8'h0C;
  localparam logic [7:0] DEF_OPT_B = 8'h90;
  localparam logic [7:0] DEF_PORT = 8'h00;
  localparam logic [7:0] DEF_DRAW_SELF = 8'h01;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Units and timing
  // ----------------------------------------------------------------
  localparam int DRAW_UNIT_MA = 2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int OC_T0_NS = 100_000;
  localparam int OC_T1_NS = 2_000_000;
  localparam int OC_T2_NS = 4_000_000;
  localparam int OC_T3_NS = 6_000_000;
  localparam int OC_DLY0_CYC = (OC_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_DLY1_CYC = (OC_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_DLY2_CYC = (OC_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_DLY3_CYC = (OC_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CNT_W = 19;

  typedef enum logic [1:0] {
    HCOB_DELAY_0P1MS,
    HCOB_DELAY_2MS,
    HCOB_DELAY_4MS,
    HCOB_DELAY_6MS
  } hcob_delay_type;

endpackage

// File: verilog/hcob_ovl_if.sv
// Carrier between option bank and overload delay timer
`timescale 1ns/1ns
interface hcob_ovl_if #(parameter int CNT_W = 19);
  logic enable;
  logic fault_raw;
  logic [CNT_W-1:0] limit;
  logic fault;

  modport bank (output enable, output fault_raw, output limit, input fault);
  modport timer (input enable, input fault_raw, input limit, output fault);
endinterface

// File: verilog/hcob_ovl_timer.sv
// Overload delay timer: qualifies a sustained overload
`timescale 1ns/1ns
module hcob_ovl_timer
  import hcob_pkg::*;
#(
  parameter int CNT_W = 19
)
(
  input wire logic mclk,
  input wire logic rst,
  hcob_ovl_if.timer ovl
);

  typedef enum logic [1:0] {
    HCOB_IDLE,
    HCOB_COUNT,
    HCOB_TRIPPED
  } hcob_tstate_type;

  hcob_tstate_type state_q;
  hcob_tstate_type state_d;
  logic [CNT_W-1:0] cnt_q;
  logic fault_q;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      HCOB_IDLE:
      begin
        if (ovl.enable && ovl.fault_raw)
          state_d = HCOB_COUNT;
      end
      HCOB_COUNT:
      begin
        if (!ovl.enable || !ovl.fault_raw)
          state_d = HCOB_IDLE;
        else if (cnt_q >= ovl.limit - CNT_W'(1))
          state_d = HCOB_TRIPPED;
      end
      HCOB_TRIPPED:
      begin
        if (!ovl.enable || !ovl.fault_raw)
          state_d = HCOB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_q <= HCOB_IDLE;
    else
      state_q <= state_d;
  end

  // Counts only while the overload stays present
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (state_q == HCOB_COUNT && state_d == HCOB_COUNT)
      cnt_q <= cnt_q + CNT_W'(1);
    else
      cnt_q <= '0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      fault_q <= 1'b0;
    else
      fault_q <= (state_d == HCOB_TRIPPED);
  end

  assign ovl.fault = fault_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_trip_after_delay;
    @(posedge mclk) disable iff (rst)
    $rose(fault_q) |-> $past(cnt_q) >= $past(ovl.limit) - CNT_W'(1);
  endproperty
  a_trip_after_delay: assert property (p_trip_after_delay) else $error("overload tripped early");

  property p_release_clears;
    @(posedge mclk) disable iff (rst)
    !ovl.fault_raw |=> !fault_q;
  endproperty
  a_release_clears: assert property (p_release_clears) else $error("fault held after release");

endmodule

// File: bench/hcob_loader_model.sv
// Byte loader model standing in for the configuration source
`timescale 1ns/1ns
module hcob_loader_model
  import hcob_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  output logic cfg_load_done
);
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    cfg_load_done = 1'b0;
  end

  // ----------------------------------------------------------------
  // Byte transfers, one strobe cycle each
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_DRAW_SELF && v > 8'h32)
      v = 8'h32;
    @(negedge mclk);
    cfg_addr = a;
    cfg_wdata = v;
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
    // Released data shows the inverse, never the stale byte
    cfg_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(negedge mclk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge mclk);
    cfg_rd = 1'b0;
    for (int n = 0; n < 3 && cfg_rvalid !== 1'b1; n++)
      @(negedge mclk);
    if (cfg_rvalid === 1'b1)
      d = cfg_rdata;
  endtask

  task automatic finish_load();
    @(negedge mclk);
    cfg_load_done = 1'b1;
    @(negedge mclk);
    cfg_load_done = 1'b0;
  endtask
endmodule

// File: bench/hub_config_option_bytes_bench.sv
// Self-checking bench for the hub option byte bank
`timescale 1ns/1ns
module hub_config_option_bytes_bench
  import hcob_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sense = 1'b1;
  logic ovl_n = 1'b1;
  logic cfg_wr, cfg_rd, cfg_load_done, cfg_rvalid, attach, self_p, fs_only, eop_off, sns_off, fault, compound;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, draw;
  logic [2:1] fixed, port_en;
  logic [8:0] draw_ma;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] defs [6] = '{DEF_OPT_A_SELF, DEF_OPT_B, DEF_PORT, DEF_PORT, DEF_PORT, DEF_DRAW_SELF};
  logic [7:0] masks [5] = '{MASK_OPT_A, MASK_OPT_B, MASK_PORT, MASK_PORT, MASK_PORT};

  always #10 mclk = ~mclk;

  hcob_loader_model loader (.mclk(mclk), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_load_done(cfg_load_done));

  hcob_bank #(.DLY0_CYC(4), .DLY1_CYC(8), .DLY2_CYC(12), .DLY3_CYC(16)) uut (.mclk(mclk), .rst(rst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_load_done(cfg_load_done),
    .local_power_sense_pin(sense), .overload_n_pin(ovl_n), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .hub_attach_enable(attach), .self_powered(self_p), .full_speed_only(fs_only), .frame_end_marker_off(eop_off),
    .overload_sense_off(sns_off), .overload_fault(fault), .compound_device(compound), .fixed_port_bits(fixed),
    .port_enabled(port_en), .max_draw_self_value(draw), .max_draw_self_ma(draw_ma));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    loader.rd(a, d);
    chk(9'(d), 9'(exp));
  endtask

  // Applied outputs land one edge after the strobe edge
  task automatic wset(input logic [7:0] a, input logic [7:0] d);
    loader.wr(a, d);
    repeat (2) @(negedge mclk);
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(9'({self_p, fs_only, eop_off, sns_off, compound, attach}), 9'h028);
    chk(9'({fixed, port_en}), 9'h003);
    chk(draw_ma, 9'h002);
    for (int i = 0; i < 6; i++)
      rdchk(8'h06 + 8'(i), defs[i]);
    rdchk(8'h0C, DATA_ZERO);
  endtask

  task automatic t_reserved();
    for (int i = 0; i < 5; i++)
    begin
      loader.wr(8'h06 + 8'(i), 8'hFF);
      rdchk(8'h06 + 8'(i), masks[i]);
    end
    wset(8'h0C, 8'hFF);
    rdchk(8'h0C, DATA_ZERO);
    chk(9'({fs_only, eop_off, sns_off, compound, fixed, port_en}), 9'h0DC);
  endtask

  task automatic t_power();
    wset(ADDR_OPT_B, 8'h00);
    // Pin drops while switching is off: mode must hold
    sense = 1'b0;
    wset(ADDR_OFF_BUS, 8'h02);
    chk(9'(self_p), 9'h001);
    wset(ADDR_OPT_A, 8'h00);
    chk(9'({self_p, fs_only, eop_off, sns_off, port_en}), 9'h002);
    wset(ADDR_OPT_A, 8'h20);
    chk(9'({self_p, fs_only}), 9'h001);
    wset(ADDR_OPT_A, 8'h04);
    chk(9'({self_p, sns_off}), 9'h001);
    // Reserved sense code acts as ganged sensing
    wset(ADDR_OPT_A, 8'h02);
    chk(9'({self_p, sns_off}), 9'h000);
    wset(ADDR_OPT_A, 8'h84);
    chk(9'({self_p, sns_off, port_en}), 9'h008);
    wset(ADDR_OFF_SELF, 8'h04);
    chk(9'(port_en), 9'h001);
    wset(ADDR_OPT_B, 8'h80);
    chk(9'({self_p, port_en}), 9'h002);
    sense = 1'b1;
    repeat (4) @(negedge mclk);
    chk(9'({self_p, port_en}), 9'h005);
  endtask

  task automatic t_draw();
    wset(ADDR_DRAW_SELF, 8'h32);
    chk(draw_ma, 9'h064);
    chk(9'(draw), 9'h032);
    rdchk(ADDR_DRAW_SELF, 8'h32);
  endtask

  task automatic t_overload();
    int lim;
    wset(ADDR_OPT_A, 8'h80);
    for (int k = 0; k < 4; k++)
    begin
      lim = 4 * (k + 1);
      wset(ADDR_OPT_B, 8'h80 | 8'(k << 4));
      ovl_n = 1'b0;
      repeat (lim) @(negedge mclk);
      chk(9'(fault), 9'h000);
      for (int n = 0; n < 10 && fault !== 1'b1; n++)
        @(negedge mclk);
      chk(9'(fault), 9'h001);
      ovl_n = 1'b1;
      repeat (8) @(negedge mclk);
      chk(9'(fault), 9'h000);
    end
    // Short dip under the shortest delay must not trip
    wset(ADDR_OPT_B, 8'h80);
    ovl_n = 1'b0;
    repeat (2) @(negedge mclk);
    ovl_n = 1'b1;
    repeat (16) @(negedge mclk);
    chk(9'(fault), 9'h000);
    // Sensing off while bus powered: overload never qualifies
    wset(ADDR_OPT_B, 8'h00);
    wset(ADDR_OPT_A, 8'h04);
    ovl_n = 1'b0;
    repeat (30) @(negedge mclk);
    chk(9'({self_p, sns_off, fault}), 9'h002);
    ovl_n = 1'b1;
  endtask

  task automatic t_attach();
    chk(9'(attach), 9'h000);
    loader.finish_load();
    repeat (3) @(negedge mclk);
    chk(9'(attach), 9'h001);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_reserved();
    t_power();
    t_draw();
    t_overload();
    t_attach();
    give_verdict();
  end

  initial
  begin
    #100_000;
    n_fail++;
    give_verdict();
  end
endmodule
